//--- core/cmbf_fabric.sv
// Core memory bus fabric: program, primary, secondary and peripheral paths
// Behaviour
// - 21-bit program address returns addressed 16-bit word on program read bus
// - Program memory writes use only low 16 bits of write bus
// - Primary reads return up to 32 bits at primary address
// - Primary writes store up to 32 bits of write bus data at primary address
// - Primary address supports byte, word and long sizes
// - Primary address also decodes memory-mapped peripheral registers
// - Byte accesses force the address MSB to zero
// - Secondary address carries second simultaneous access, words only
// - Dual reads return secondary word on 16-bit secondary read bus
// - 16-bit peripheral bus reaches every peripheral register
// - Peripheral bus runs at data memory rate, no extra waits
// - Peripheral writes from write bus, reads onto read bus
`timescale 1ns/100ps
`default_nettype none
module cmbf_fabric (
  input wire logic clk,
  input wire logic rst_n,
  input wire cmbf_pkg::cmbf_preq_t preq,
  input wire cmbf_pkg::cmbf_xreq_t xreq,
  input wire cmbf_pkg::cmbf_x2req_t x2req,
  input wire logic [31:0] cdbw,
  output logic [15:0] prog_read_data,
  output logic [31:0] cdbr_m,
  output logic [15:0] secondary_read_data,
  output logic per_sel_ff,
  output logic per_wr_ff,
  output logic per_rd_ff,
  output logic [5:0] per_addr_ff,
  output logic [15:0] per_wdata_ff,
  input wire logic [15:0] per_rdata
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [23:0] xaddr;
  logic x_is_per;
  logic [7:0] dword_idx;
  logic [7:0] dword2_idx;
  logic [1:0] x_lane;

  // Byte accesses live in the lower half only
  always_comb begin
    xaddr = xreq.addr;
    if (xreq.size == cmbf_pkg::CMBF_SZ_BYTE) begin
      xaddr[cmbf_pkg::MSB_POS] = 1'b0;
    end
  end

  assign x_is_per = (xaddr & cmbf_pkg::PER_MASK) == cmbf_pkg::PER_BASE;
  // Data memory is 32-bit wide: xab counts 16-bit words, byte address is dword*4+lane
  assign dword_idx = xaddr[8:1];
  assign x_lane = {xaddr[0], 1'b0};
  assign dword2_idx = x2req.addr[8:1];

  ////////////////////////////////////////////////////////////////////////
  // Program memory

  logic [15:0] pmem [0:255];
  logic [15:0] prog_word;

  assign prog_word = pmem[preq.addr[7:0]];

  always_ff @(posedge clk) begin
    if (preq.wr) begin
      pmem[preq.addr[7:0]] <= cdbw[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prog_read_data <= cmbf_pkg::PDATA_RST;
    end else if (preq.rd) begin
      prog_read_data <= prog_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data memory, byte lanes per generate

  wire logic [31:0] dword_rd;
  wire logic [31:0] dword2_rd;
  logic [3:0] lane_we;
  logic x_mem_wr;

  assign x_mem_wr = xreq.wr && !x_is_per;

  // Lane enables by size; word half picked by address bit 0
  always_comb begin
    lane_we = 4'h0;
    unique case (xreq.size)
      cmbf_pkg::CMBF_SZ_BYTE: lane_we = 4'h1 << x_lane;
      cmbf_pkg::CMBF_SZ_WORD: lane_we = 4'h3 << x_lane;
      cmbf_pkg::CMBF_SZ_LONG: lane_we = 4'hF;
      default: lane_we = 4'h0;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      logic [7:0] wbyte;
      // Narrow writes take low bits of cdbw, shifted onto the lane
      assign wbyte = (xreq.size == cmbf_pkg::CMBF_SZ_LONG) ? cdbw[8*g +: 8] :
                     (xreq.size == cmbf_pkg::CMBF_SZ_WORD) ? cdbw[8*(g%2) +: 8] : cdbw[7:0];
      // One array per lane keeps a single writer per memory
      logic [7:0] lane_mem [0:255];
      always_ff @(posedge clk) begin
        if (x_mem_wr && lane_we[g]) begin
          lane_mem[dword_idx] <= wbyte;
        end
      end
      assign dword_rd[8*g +: 8] = lane_mem[dword_idx];
      assign dword2_rd[8*g +: 8] = lane_mem[dword2_idx];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Primary read and peripheral read return

  logic [31:0] x_rd_val;
  logic per_rd_pend_ff;
  logic mem_rd_pend_ff;
  logic [31:0] mem_rd_ff;

  always_comb begin
    x_rd_val = 32'h0000_0000;
    unique case (xreq.size)
      cmbf_pkg::CMBF_SZ_BYTE: x_rd_val = {24'h000000, dword_rd[8*x_lane +: 8]};
      cmbf_pkg::CMBF_SZ_WORD: x_rd_val = {16'h0000, dword_rd[8*x_lane +: 16]};
      default: x_rd_val = dword_rd;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_rd_ff <= cmbf_pkg::RDATA_RST;
    end else if (xreq.rd && !x_is_per) begin
      mem_rd_ff <= x_rd_val;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      per_rd_pend_ff <= 1'b0;
      mem_rd_pend_ff <= 1'b0;
    end else begin
      per_rd_pend_ff <= xreq.rd && x_is_per;
      mem_rd_pend_ff <= xreq.rd && !x_is_per;
    end
  end

  // Memory data staged one cycle so both sources return on the same edge, no waits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cdbr_m <= cmbf_pkg::RDATA_RST;
    end else if (per_rd_pend_ff) begin
      cdbr_m <= {16'h0000, per_rdata};
    end else if (mem_rd_pend_ff) begin
      cdbr_m <= mem_rd_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Secondary read path, words only

  logic [15:0] sec_word;
  logic [15:0] sec_rd_ff;
  logic sec_rd_pend_ff;

  assign sec_word = x2req.addr[0] ? dword2_rd[31:16] : dword2_rd[15:0];

  // Staged like the primary path so a dual read lands alongside it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sec_rd_ff <= cmbf_pkg::PDATA_RST;
      sec_rd_pend_ff <= 1'b0;
    end else begin
      sec_rd_pend_ff <= x2req.rd;
      if (x2req.rd) begin
        sec_rd_ff <= sec_word;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      secondary_read_data <= cmbf_pkg::PDATA_RST;
    end else if (sec_rd_pend_ff) begin
      secondary_read_data <= sec_rd_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Peripheral register bus, same clock as data memory

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      per_sel_ff <= 1'b0;
      per_wr_ff <= 1'b0;
      per_rd_ff <= 1'b0;
      per_addr_ff <= 6'h00;
      per_wdata_ff <= 16'h0000;
    end else begin
      per_sel_ff <= x_is_per && (xreq.rd || xreq.wr);
      per_wr_ff <= x_is_per && xreq.wr;
      per_rd_ff <= x_is_per && xreq.rd;
      per_addr_ff <= xaddr[5:0];
      per_wdata_ff <= cdbw[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence per_read_s;
    xreq.rd && x_is_per;
  endsequence

  sequence mem_read_s;
    xreq.rd && !x_is_per;
  endsequence

  per_rd_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
    per_read_s |=> per_rd_ff && per_sel_ff)
    else $error("peripheral read strobe missing");
  per_rd_return_a: assert property (@(posedge clk) disable iff (!rst_n)
    per_read_s ##1 1'b1 |=> cdbr_m == {16'h0000, $past(per_rdata)})
    else $error("peripheral read data not returned");
  per_wr_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    xreq.wr && x_is_per |=> per_wr_ff && per_wdata_ff == $past(cdbw[15:0]))
    else $error("peripheral write data wrong");
  byte_msb_a: assert property (@(posedge clk) disable iff (!rst_n)
    xreq.rd && xreq.size == cmbf_pkg::CMBF_SZ_BYTE &&
    ((xreq.addr & cmbf_pkg::PER_MASK) == (cmbf_pkg::PER_BASE | 24'h800000)) |=> per_rd_ff)
    else $error("byte access MSB not cleared");
  per_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (xreq.rd || xreq.wr) && x_is_per |=> per_addr_ff == $past(xaddr[5:0]))
    else $error("peripheral address wrong");
  mem_no_per_a: assert property (@(posedge clk) disable iff (!rst_n)
    xreq.rd && !x_is_per |=> !per_rd_ff)
    else $error("memory read leaked to peripheral bus");
  prog_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    preq.rd && !preq.wr |=> prog_read_data == $past(prog_word))
    else $error("program read data wrong");
  prim_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    mem_read_s |=> ##1 cdbr_m == $past(x_rd_val, 2))
    else $error("primary read data wrong");
  sec_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    x2req.rd |=> ##1 secondary_read_data == $past(sec_word, 2))
    else $error("secondary read data wrong");

endmodule : cmbf_fabric
`default_nettype wire

//--- core/cmbf_pkg.sv
// Package for the core memory bus fabric: widths, map and carrier structs
package cmbf_pkg;
  localparam int unsigned PAB_W = 21;
  localparam int unsigned PDB_W = 16;
  localparam int unsigned XAB_W = 24;
  localparam int unsigned CDB_W = 32;
  localparam int unsigned XDB2_W = 16;
  localparam int unsigned PER_W = 16;
  // Memory address widths in bits and the peripheral window (plain defaults)
  localparam int unsigned PMEM_AW = 8;
  localparam int unsigned DMEM_AW = 8;
  localparam int unsigned PER_AW = 6;
  localparam logic [23:0] PER_BASE = 24'h00F000;
  localparam logic [23:0] PER_MASK = 24'hFFF000;
  localparam int unsigned MSB_POS = 23;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [15:0] PDATA_RST = 16'h0000;

  typedef enum logic [2:0] {
    CMBF_SZ_BYTE = 3'h1,
    CMBF_SZ_WORD = 3'h2,
    CMBF_SZ_LONG = 3'h4
  } cmbf_size_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [PAB_W-1:0] addr;
  } cmbf_preq_t;

  typedef struct packed {
    logic rd;
    logic wr;
    cmbf_size_t size;
    logic [XAB_W-1:0] addr;
  } cmbf_xreq_t;

  typedef struct packed {
    logic rd;
    logic [XAB_W-1:0] addr;
  } cmbf_x2req_t;
endpackage : cmbf_pkg

//--- sim/cmbf_fabric_tb_top.sv
// Self-checking bench for the core memory bus fabric
`timescale 1ns/100ps
`default_nettype none
module cmbf_fabric_tb_top;
  typedef struct {int t; int sel; logic [31:0] v;} cmbf_note_t;
  localparam logic [2:0] SZ_B = cmbf_pkg::CMBF_SZ_BYTE;
  localparam logic [2:0] SZ_W = cmbf_pkg::CMBF_SZ_WORD;
  localparam logic [2:0] SZ_L = cmbf_pkg::CMBF_SZ_LONG;
  logic clk, rst_n, per_sel, per_wr, per_rd;
  cmbf_pkg::cmbf_preq_t preq;
  cmbf_pkg::cmbf_xreq_t xreq;
  cmbf_pkg::cmbf_x2req_t x2req;
  logic [31:0] cdbw, cdbr_m, seed;
  logic [15:0] prd, srd, per_wdata, per_rdata;
  logic [5:0] per_addr;
  logic [15:0] pm [256];
  logic [31:0] dm [256];
  logic [15:0] pr [64];
  cmbf_note_t exp_q [$];
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  cmbf_fabric dut_u (.clk(clk), .rst_n(rst_n), .preq(preq), .xreq(xreq), .x2req(x2req), .cdbw(cdbw),
    .prog_read_data(prd), .cdbr_m(cdbr_m), .secondary_read_data(srd), .per_sel_ff(per_sel),
    .per_wr_ff(per_wr), .per_rd_ff(per_rd), .per_addr_ff(per_addr), .per_wdata_ff(per_wdata),
    .per_rdata(per_rdata));
  cmbf_periph_model per_u (.clk(clk), .sel(per_sel), .wr(per_wr), .rd(per_rd), .addr(per_addr),
    .wdata(per_wdata), .rdata(per_rdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic cmbf_pkg::cmbf_xreq_t xr(input logic r, input logic w, input logic [2:0] s,
      input logic [23:0] a);
    return {r, w, s, a};
  endfunction : xr
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic op(input cmbf_pkg::cmbf_preq_t p, input cmbf_pkg::cmbf_xreq_t x,
      input cmbf_pkg::cmbf_x2req_t x2, input logic [31:0] w);
    @(posedge clk);
    preq <= p;
    xreq <= x;
    x2req <= x2;
    cdbw <= w;
  endtask : op
  // Latency counts from the launching edge: program 2, data memory and peripheral 3
  task automatic note(input int lat, input int sel, input logic [31:0] v);
    exp_q.push_back('{cyc + lat, sel, v});
  endtask : note
  task automatic test_done();
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever begin
      @(posedge clk);
      #1;
      while (exp_q.size() > 0 && exp_q[0].t <= cyc) begin
        check(exp_q[0].sel == 0 ? "prog" : exp_q[0].sel == 1 ? "primary" : "secondary", exp_q[0].v,
          exp_q[0].sel == 0 ? {16'h0000, prd} : exp_q[0].sel == 1 ? cdbr_m : {16'h0000, srd});
        void'(exp_q.pop_front());
      end
    end
  end
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    test_done();
  end
  initial begin
    logic [23:0] a;
    logic [31:0] d;
    logic [7:0] b;
    logic [5:0] k;
    int row;
    seed = 32'h0000_DBDF;
    rst_n = 1'b0;
    preq = '0;
    xreq = '0;
    x2req = '0;
    cdbw = 32'h0000_0000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("reset", 32'h0000_0000, cdbr_m | {prd, srd} | {7'h00, per_sel, per_wr, per_rd, per_addr, per_wdata});
    for (int i = 0; i < 16; i++) begin
      d = rnd();
      row = d[8:1];
      k = d[6:1];
      a = {15'h0000, d[8:1], 1'b0};
      d = rnd();
      op('0, xr(1'b0, 1'b1, SZ_L, a), '0, d);
      dm[row] = d;
      d = rnd();
      op('0, xr(1'b0, 1'b1, SZ_W, a | 24'h000001), '0, d);
      dm[row][31:16] = d[15:0];
      b = d[31:24];
      op('0, xr(1'b0, 1'b1, SZ_B, a | 24'h800000), '0, {4{b}});
      dm[row][7:0] = b;
      op('0, xr(1'b1, 1'b0, SZ_L, a), '0, 32'h0000_0000);
      note(3, 1, dm[row]);
      op('0, xr(1'b1, 1'b0, SZ_W, a | 24'h000001), {1'b1, a}, 32'h0000_0000);
      note(3, 1, {16'h0000, dm[row][31:16]});
      note(3, 2, {16'h0000, dm[row][15:0]});
      d = rnd();
      op({2'b01, 13'h0000, a[8:1]}, xr(1'b1, 1'b0, SZ_B, a | 24'h800001), '0, d);
      pm[row] = d[15:0];
      note(3, 1, {24'h000000, dm[row][23:16]});
      d = rnd();
      op({2'b10, 13'h0000, a[8:1]}, xr(1'b0, 1'b1, SZ_W, 24'h00F000 | k), '0, d);
      pr[k] = d[15:0];
      note(2, 0, {16'h0000, pm[row]});
      op('0, xr(1'b1, 1'b0, SZ_W, 24'h00F000 | k), '0, 32'h0000_0000);
      note(3, 1, {16'h0000, pr[k]});
      op('0, xr(1'b1, 1'b0, SZ_B, 24'h80F000 | k), '0, 32'h0000_0000);
      op('0, '0, '0, 32'h0000_0000);
      #1;
      check("byte decode", {25'h0000000, 1'b1, k}, {25'h0000000, per_rd, per_addr});
    end
    op('0, '0, '0, 32'h0000_0000);
    repeat (6) @(posedge clk);
    test_done();
  end
endmodule : cmbf_fabric_tb_top
`default_nettype wire

//--- sim/cmbf_periph_model.sv
// Peripheral register bank model for the fabric bench
`timescale 1ns/100ps
`default_nettype none
module cmbf_periph_model (
  input wire logic clk,
  input wire logic sel,
  input wire logic wr,
  input wire logic rd,
  input wire logic [5:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [15:0] regs_ff [64];
  logic [15:0] last_ff;
  always_ff @(posedge clk) begin
    if (sel && wr) begin
      regs_ff[addr] <= wdata;
    end
    if (sel && rd) begin
      last_ff <= regs_ff[addr];
    end
  end
  // Released bus shows the inverse, so a stale value never passes
  assign rdata = (sel && rd) ? regs_ff[addr] : ~last_ff;
endmodule : cmbf_periph_model
`default_nettype wire
